/* File: hdl/epi_top.sv */
// External pin interrupt controller: sense, flags, mask, vectoring
// Functional notes
// RULE1: Pin-one sense: low, change, fall, rise
// RULE2: Pin-zero sense uses the same encoding
// RULE3: Pins zero/one sampled before edge detection
// RULE4: Source holds low level until instruction ends
// RULE5: Pin-two select: zero falling, one rising
// RULE6: Pin-two edges captured without a clock
// RULE7: Changing pin-two select may raise request
// RULE8: Software disables, reselects, clears, then re-enables
// RULE9: Request needs mask bit and global enable
// RULE10: Pins still detected when driven as outputs
// RULE11: Each pin has its own vector
// RULE12: Detected edge or change sets pending flag
// RULE13: Taken vector or written one clears flag
// RULE14: Flags forced zero in low-level mode
// RULE15: Sleep buffer disable may set pin-two flag
// RULE16: Low level requests continuously while low
// RULE17: Low levels and pin-two edges wake clocklessly
// RULE18: Two-stage synchroniser, compare with previous sample
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module epi_top (
    input  wire logic       clk_sys,      // System clock, 20 MHz
    input  wire logic       rst,          // Synchronous reset, active high
    input  wire logic       pin_zero,     // ext_irq_pin_zero level
    input  wire logic       pin_one,      // ext_irq_pin_one level
    input  wire logic       pin_two,      // ext_irq_pin_two level
    input  wire logic       sleep_buf_off,// Sleep wants unused buffers off
    input  wire logic       global_ie,    // core_status_word global enable
    input  wire logic [7:0] reg_addr,     // Register address
    input  wire logic [7:0] reg_wdata,    // Register write data
    input  wire logic       reg_wr,       // Write strobe
    input  wire logic       reg_rd,       // Read strobe
    output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
    input  wire logic       vec_ack,      // Core takes presented vector
    output logic            irq,          // Interrupt request level
    output logic      [1:0] irq_vec_id,   // Vector of the request
    output logic            wake_req      // Clockless wake request
);
    import epi_pkg::*;

    // Synchronisers and previous sample for pins zero and one
    logic [1:0] s1_q, s1_d;
    logic [1:0] s2_q, s2_d;
    logic [1:0] prev_q, prev_d;

    // Software registers
    logic [7:0] ctla_q, ctla_d;
    logic [7:0] ctlb_q, ctlb_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] flag_q, flag_d;
    logic [7:0] rdata_q, rdata_d;

    // Vector presentation and pin-two handshake
    logic       irq_q, irq_d;
    logic [1:0] vid_q, vid_d;
    logic       p2_clr_q, p2_clr_d;

    logic       p2_pin_int;
    logic       p2_raw;
    logic       p2_seen;
    logic       p2_evt;
    logic [1:0] sense0, sense1;
    logic       lvl0, lvl1;
    logic       ev0, ev1;
    logic       req0, req1, req2;
    logic       wr_ctla, wr_ctlb, wr_mask, wr_flags;
    logic [7:0] w1c;
    logic [7:0] ack_clr;
    logic [7:0] set_bits;

    // Edge or change hit for one sense code on synchronised samples
    function automatic logic sense_hit(input logic [1:0] sense,
                                       input logic       cur,
                                       input logic       prev);
        logic hit;
        hit = 1'b0;
        unique case (sense)
            EPI_SENSE_LOW:  hit = 1'b0;           // Level handled apart
            EPI_SENSE_ANY:  hit = cur ^ prev;
            EPI_SENSE_FALL: hit = prev & ~cur;
            EPI_SENSE_RISE: hit = cur & ~prev;
        endcase
        return hit;
    endfunction

    // Address decode shared by read and write paths
    function automatic logic hit_off(input logic [7:0] a,
                                     input logic [7:0] off);
        return a == off;
    endfunction

    // Sense fields and level mode flags
    assign sense1 = ctla_q[EPI_P1_SENSE_LSB +: 2];
    assign sense0 = ctla_q[EPI_P0_SENSE_LSB +: 2];
    assign lvl1   = sense1 == EPI_SENSE_LOW;
    assign lvl0   = sense0 == EPI_SENSE_LOW;

    // Pin seen internally no matter who drives it
    always_comb
    begin
        s1_d   = {pin_one, pin_zero};  // see RULE10
        s2_d   = s1_q;                 // see RULE18
        prev_d = s2_q;                 // see RULE3
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1_q   <= 2'h3;
            s2_q   <= 2'h3;
            prev_q <= 2'h3;
        end
        else
        begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
        end
    end

    // Edge events; a pulse over one period lands in the samples
    assign ev0 = sense_hit(sense0, s2_q[0], prev_q[0]);  // see RULE2
    assign ev1 = sense_hit(sense1, s2_q[1], prev_q[1]);  // see RULE1

    // Buffer off in sleep while disabled pulls the internal node low
    assign p2_pin_int = pin_two &
                        ~(sleep_buf_off & ~mask_q[EPI_P2_BIT]);  // see RULE15

    epi_async_edge u_p2 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   (p2_pin_int),
        .edge_sel (ctlb_q[EPI_P2_SEL_BIT]),
        .clr_req  (p2_clr_q),
        .cap_raw  (p2_raw),
        .cap_seen (p2_seen)
    );

    // One event per capture: clear held until the synchroniser drops
    assign p2_evt   = p2_seen & ~p2_clr_q;  // see RULE6
    assign p2_clr_d = p2_seen;

    // Requests gated by their mask bits
    assign req0 = mask_q[EPI_P0_BIT] &
                  (lvl0 ? ~s2_q[0] : flag_q[EPI_P0_BIT]);  // see RULE16
    assign req1 = mask_q[EPI_P1_BIT] &
                  (lvl1 ? ~s2_q[1] : flag_q[EPI_P1_BIT]);  // see RULE16
    assign req2 = mask_q[EPI_P2_BIT] & flag_q[EPI_P2_BIT];

    // Write decode
    assign wr_ctla  = reg_wr & hit_off(reg_addr, EPI_OFF_CTLA);
    assign wr_ctlb  = reg_wr & hit_off(reg_addr, EPI_OFF_CTLB);
    assign wr_mask  = reg_wr & hit_off(reg_addr, EPI_OFF_MASK);
    assign wr_flags = reg_wr & hit_off(reg_addr, EPI_OFF_FLAGS);
    assign w1c      = wr_flags ? reg_wdata : 8'h00;  // see RULE13

    // Vector taken clears its own flag only
    always_comb
    begin
        ack_clr = 8'h00;
        if (vec_ack && irq_q)
        begin
            unique case (vid_q)
                EPI_VEC_P0: ack_clr[EPI_P0_BIT] = 1'b1;  // see RULE13
                EPI_VEC_P1: ack_clr[EPI_P1_BIT] = 1'b1;
                default:    ack_clr[EPI_P2_BIT] = 1'b1;
            endcase
        end
    end

    // Flag next state: set beats clear, level mode forces zero
    always_comb
    begin
        set_bits              = 8'h00;
        set_bits[EPI_P0_BIT]  = ev0;      // see RULE12
        set_bits[EPI_P1_BIT]  = ev1;      // see RULE12
        set_bits[EPI_P2_BIT]  = p2_evt;   // see RULE12
        flag_d = ((flag_q & ~(w1c | ack_clr)) | set_bits) & EPI_FLAG_BITS;
        if (lvl0)
            flag_d[EPI_P0_BIT] = 1'b0;    // see RULE14
        if (lvl1)
            flag_d[EPI_P1_BIT] = 1'b0;    // see RULE14
    end

    // Control register next state
    always_comb
    begin
        ctla_d = wr_ctla ? reg_wdata : ctla_q;
        ctlb_d = wr_ctlb ? reg_wdata : ctlb_q;
        mask_d = wr_mask ? reg_wdata : mask_q;
    end

    // Read mux; unmapped addresses read as zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            if (hit_off(reg_addr, EPI_OFF_CTLA))
                rdata_d = ctla_q;
            else if (hit_off(reg_addr, EPI_OFF_CTLB))
                rdata_d = ctlb_q;
            else if (hit_off(reg_addr, EPI_OFF_MASK))
                rdata_d = mask_q;
            else if (hit_off(reg_addr, EPI_OFF_FLAGS))
                rdata_d = flag_q;
        end
    end

    // Vector choice: lowest vector number wins
    always_comb
    begin
        irq_d = global_ie & (req0 | req1 | req2);  // see RULE9
        if (req0)
            vid_d = EPI_VEC_P0;                    // see RULE11
        else if (req1)
            vid_d = EPI_VEC_P1;
        else if (req2)
            vid_d = EPI_VEC_P2;
        else
            vid_d = vid_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctla_q   <= EPI_RST_REG;
            ctlb_q   <= EPI_RST_REG;
            mask_q   <= EPI_RST_REG;
            flag_q   <= EPI_RST_REG;
            rdata_q  <= EPI_RST_REG;
            irq_q    <= 1'b0;
            vid_q    <= EPI_VEC_P0;
            p2_clr_q <= 1'b0;
        end
        else
        begin
            ctla_q   <= ctla_d;
            ctlb_q   <= ctlb_d;
            mask_q   <= mask_d;
            flag_q   <= flag_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
            vid_q    <= vid_d;
            p2_clr_q <= p2_clr_d;
        end
    end

    // Wake path uses raw pins so it works with the clock stopped
    assign wake_req = (mask_q[EPI_P0_BIT] & lvl0 & ~pin_zero) |
                      (mask_q[EPI_P1_BIT] & lvl1 & ~pin_one)  |
                      (mask_q[EPI_P2_BIT] & p2_raw);  // see RULE17

    assign reg_rdata  = rdata_q;
    assign irq        = irq_q;
    assign irq_vec_id = vid_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_level_no_flag: assert property ( // see RULE14
        lvl0 |=> !flag_q[EPI_P0_BIT])
        else $error("pin zero flag set in level mode");

    a_p1_rise_flag: assert property ( // see RULE1
        (sense1 == EPI_SENSE_RISE && s2_q[1] && !prev_q[1])
        |=> flag_q[EPI_P1_BIT])
        else $error("pin one rise did not set flag");

    a_p1_any_flag: assert property ( // see RULE12
        (sense1 == EPI_SENSE_ANY && s2_q[1] != prev_q[1])
        |=> flag_q[EPI_P1_BIT])
        else $error("pin one change did not set flag");

    a_p0_fall_flag: assert property ( // see RULE2
        (sense0 == EPI_SENSE_FALL && $fell(pin_zero) && !wr_ctla)
        ##1 !wr_ctla ##1 !wr_ctla |=> flag_q[EPI_P0_BIT])
        else $error("pin zero fall not flagged after sampling");

    a_irq_gated: assert property ( // see RULE9
        irq_q |-> $past(global_ie) && $past(req0 | req1 | req2))
        else $error("interrupt without enable and mask");

    a_level_holds: assert property ( // see RULE16
        (lvl0 && !s2_q[0] && mask_q[EPI_P0_BIT] && global_ie)
        |=> irq_q && vid_q == EPI_VEC_P0)
        else $error("low level did not keep requesting");

    a_ack_clears: assert property ( // see RULE13
        (vec_ack && irq_q && vid_q == EPI_VEC_P1 && !ev1)
        |=> !flag_q[EPI_P1_BIT])
        else $error("taken vector did not clear its flag");

    a_w1c_clears: assert property ( // see RULE13
        (wr_flags && reg_wdata[EPI_P2_BIT] && !p2_evt)
        |=> !flag_q[EPI_P2_BIT])
        else $error("write one did not clear pin two flag");

    a_p2_capture: assert property ( // see RULE6
        $rose(p2_seen) |=> flag_q[EPI_P2_BIT] && p2_clr_q)
        else $error("pin two capture not flagged");

    a_vec_priority: assert property ( // see RULE11
        $changed(vid_q) && vid_q == EPI_VEC_P2 |-> !$past(req0 | req1))
        else $error("pin two vector chosen over a lower one");

    a_read_unmapped: assert property (
        (reg_rd && reg_addr > EPI_OFF_FLAGS) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_p1_level_flag: assert property ( // see RULE14
        lvl1 |=> !flag_q[EPI_P1_BIT])
        else $error("pin one flag set in level mode");

    a_p1_fall_flag: assert property ( // see RULE1
        (sense1 == EPI_SENSE_FALL && !s2_q[1] && prev_q[1])
        |=> flag_q[EPI_P1_BIT])
        else $error("pin one fall did not set flag");

    a_p0_any_flag: assert property ( // see RULE2
        (sense0 == EPI_SENSE_ANY && s2_q[0] != prev_q[0])
        |=> flag_q[EPI_P0_BIT])
        else $error("pin zero change did not set flag");

    a_no_ie_quiet: assert property ( // see RULE9
        !global_ie |=> !irq_q)
        else $error("interrupt raised with global enable off");

    a_spare_flags: assert property ( // see RULE12
        (flag_q & ~EPI_FLAG_BITS) == 8'h00)
        else $error("unimplemented flag bit set");

    a_p2_wake: assert property ( // see RULE17
        ($rose(p2_seen) && mask_q[EPI_P2_BIT]) |-> wake_req)
        else $error("pin two capture gave no wake request");

    // Read data stand only in the cycle after the strobe
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    c_p0_level: cover property (lvl0 && !s2_q[0] ##1 irq_q);
    c_p1_ack:   cover property (irq_q && vid_q == EPI_VEC_P1 && vec_ack);
    c_p2_flag:  cover property ($rose(flag_q[EPI_P2_BIT]));
    c_set_clr:  cover property (ev1 && wr_flags && reg_wdata[EPI_P1_BIT]);
endmodule // epi_top
`default_nettype wire

/* File: hdl/epi_pkg.sv */
// Constants and types shared by the external pin interrupt block
package epi_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] EPI_OFF_CTLA  = 8'h00; // core_control_a
    localparam logic [7:0] EPI_OFF_CTLB  = 8'h01; // core_control_b
    localparam logic [7:0] EPI_OFF_MASK  = 8'h02; // pin_irq_enable_mask
    localparam logic [7:0] EPI_OFF_FLAGS = 8'h03; // pin_irq_pending_flags

    // Reset values
    localparam logic [7:0] EPI_RST_REG   = 8'h00;

    // Field positions
    localparam int EPI_P1_SENSE_LSB = 2;  // pin_one_sense_hi/lo at 3:2
    localparam int EPI_P0_SENSE_LSB = 0;  // pin_zero_sense_hi/lo at 1:0
    localparam int EPI_P2_SEL_BIT   = 0;  // pin_two_edge_select
    localparam int EPI_P1_BIT       = 7;  // Mask and flag bit, pin one
    localparam int EPI_P0_BIT       = 6;  // Mask and flag bit, pin zero
    localparam int EPI_P2_BIT       = 5;  // Mask and flag bit, pin two
    localparam logic [7:0] EPI_FLAG_BITS = 8'he0; // Implemented flag bits

    // Sense field encoding for pins zero and one
    typedef enum logic [1:0] {
        EPI_SENSE_LOW  = 2'h0,
        EPI_SENSE_ANY  = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_e;

    // Vector identities, one per pin, lowest number served first
    localparam logic [1:0] EPI_VEC_P0 = 2'h0;
    localparam logic [1:0] EPI_VEC_P1 = 2'h1;
    localparam logic [1:0] EPI_VEC_P2 = 2'h2;

    // Timing
    localparam int EPI_CLK_NS   = 50;  // clk_sys period
    localparam int EPI_T_INT_NS = 50;  // Typical pin-two minimum pulse
    localparam int EPI_T_INT_CYC =
        (EPI_T_INT_NS / EPI_CLK_NS) < 1 ? 1 : (EPI_T_INT_NS / EPI_CLK_NS);
endpackage

/* File: hdl/epi_async_edge.sv */
// Clockless edge catcher for pin two with a synchronised output
`timescale 1ns/1ps
`default_nettype none
module epi_async_edge (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Synchronous reset, active high
    input  wire logic pin_in,    // Pin level after the input buffer
    input  wire logic edge_sel,  // 0 falling, 1 rising
    input  wire logic clr_req,   // Clear request from the clock domain
    output logic      cap_raw,   // Capture flop, unsynchronised
    output logic      cap_seen   // Capture, synchronised to clk_sys
);
    logic cap_q;
    logic clr_q;
    logic sync1_q;
    logic sync2_q;
    logic edge_clk;

    // Selected edge becomes a rising edge; a select change can also make one
    assign edge_clk = pin_in ~^ edge_sel;  // see RULE5, see RULE7

    // Clear is registered so no glitch reaches the asynchronous clear
    always_ff @(posedge clk_sys)
    begin
        clr_q <= rst | clr_req;
    end

    // Edge captured with no clock; works in sleep as well
    always_ff @(posedge edge_clk or posedge clr_q)
    begin
        if (clr_q)
            cap_q <= 1'b0;
        else
            cap_q <= 1'b1;  // see RULE6, see RULE17
    end

    // Two-flop synchroniser into the system domain
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= cap_q;
            sync2_q <= sync1_q;
        end
    end

    assign cap_raw  = cap_q;
    assign cap_seen = sync2_q;
endmodule // epi_async_edge
`default_nettype wire

/* File: sim/epi_pin_source.sv */
// Model of the external sources that drive the three interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epi_pin_source
    import epi_pkg::*;
(
    input  wire logic clk_sys,  // System clock
    output logic      pin_zero, // Pin zero level
    output logic      pin_one,  // Pin one level
    output logic      pin_two   // Pin two level
);
    // Pins idle high, as with a pull-up
    initial
    begin
        pin_zero = 1'b1;
        pin_one  = 1'b1;
        pin_two  = 1'b1;
    end

    // Level held until released by the caller
    task automatic drive(input int p, input logic v);
        @(posedge clk_sys);
        case (p)
            0:       pin_zero <= v;
            1:       pin_one  <= v;
            default: pin_two  <= v;
        endcase
    endtask

    // Low glitch off the clock edge, just over the minimum width
    task automatic glitch_two();
        @(posedge clk_sys);
        #10 pin_two = 1'b0;
        #(EPI_T_INT_NS + 10) pin_two = 1'b1;
    endtask
endmodule // epi_pin_source
`default_nettype wire

/* File: sim/tb_external_pin_interrupts.sv */
// Self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_external_pin_interrupts;
    import epi_pkg::*;
    logic       clk_sys       = 1'b0;
    logic       rst           = 1'b1;
    wire logic  pin_zero;
    wire logic  pin_one;
    wire logic  pin_two;
    logic       sleep_buf_off = 1'b0;
    logic       global_ie     = 1'b0;
    logic [7:0] reg_addr      = 8'h00;
    logic [7:0] reg_wdata     = 8'h00;
    logic       reg_wr        = 1'b0;
    logic       reg_rd        = 1'b0;
    logic       vec_ack       = 1'b0;
    logic [7:0] reg_rdata;
    logic       irq;
    logic [1:0] irq_vec_id;
    logic       wake_req;
    logic       rd_d          = 1'b0;
    logic [7:0] exp_q[$];
    int         bad_count     = 0;
    int         checks        = 0;
    logic [7:0] fbit [3]      = '{8'h40, 8'h80, 8'h20};
    logic [1:0] vid [3]       = '{EPI_VEC_P0, EPI_VEC_P1, EPI_VEC_P2};

    // Free-running system clock
    always #(EPI_CLK_NS / 2) clk_sys = ~clk_sys;

    epi_pin_source src (
        .clk_sys  (clk_sys),
        .pin_zero (pin_zero),
        .pin_one  (pin_one),
        .pin_two  (pin_two)
    );

    epi_top DUT (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .pin_zero      (pin_zero),
        .pin_one       (pin_one),
        .pin_two       (pin_two),
        .sleep_buf_off (sleep_buf_off),
        .global_ie     (global_ie),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .vec_ack       (vec_ack),
        .irq           (irq),
        .irq_vec_id    (irq_vec_id),
        .wake_req      (wake_req)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0)
            check(reg_rdata, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Expected value is noted when the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask

    task automatic ack();
        @(posedge clk_sys);
        vec_ack <= 1'b1;
        @(posedge clk_sys);
        vec_ack <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Sampled on the falling edge so the registered level has settled
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (irq !== 1'b1)
        begin
            check({7'h00, irq}, 8'h01);
            results();
        end
    endtask

    initial
    begin
        int         p;
        int         m;
        logic [7:0] rnd;
        void'($urandom(32'h54af4167));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        // Reset values, one unmapped place, read-only flag bits
        for (int a = 0; a < 5; a++)
            rd(8'(a), EPI_RST_REG);
        wr(8'h10, 8'hff);
        wr(EPI_OFF_FLAGS, 8'h1f);
        rd(EPI_OFF_MASK, 8'h00);
        rd(EPI_OFF_FLAGS, 8'h00);
        $display("test reset done");
        // Every sense code on both clocked pins, one edge at a time
        for (p = 0; p < 2; p++)
            for (m = 0; m < 4; m++)
            begin
                rnd = 8'($urandom());
                rnd[3:0] = 4'h0;
                rnd[2 * p +: 2] = m[1:0];
                wr(EPI_OFF_CTLA, rnd);
                rd(EPI_OFF_CTLA, rnd);
                src.drive(p, 1'b0);
                repeat (6) @(posedge clk_sys);
                rd(EPI_OFF_FLAGS, (m == 1 || m == 2) ? fbit[p] : 8'h00);
                wr(EPI_OFF_FLAGS, 8'he0);
                src.drive(p, 1'b1);
                repeat (6) @(posedge clk_sys);
                rd(EPI_OFF_FLAGS, (m == 1 || m == 3) ? fbit[p] : 8'h00);
                wr(EPI_OFF_FLAGS, 8'he0);
            end
        $display("test sense done");
        // Each pin to its own vector, held back by the global enable
        wr(EPI_OFF_CTLA, 8'h0f);
        wr(EPI_OFF_CTLB, 8'h01);
        // The select change is itself an edge; clear it before enabling
        repeat (6) @(posedge clk_sys);
        rd(EPI_OFF_FLAGS, 8'h20);
        wr(EPI_OFF_FLAGS, 8'h20);
        wr(EPI_OFF_MASK, 8'he0);
        for (p = 0; p < 3; p++)
        begin
            global_ie <= 1'b0;
            if (p == 2)
                src.glitch_two();
            else
            begin
                src.drive(p, 1'b0);
                repeat (2) @(posedge clk_sys);
                src.drive(p, 1'b1);
            end
            repeat (6) @(negedge clk_sys);
            check({7'h00, irq}, 8'h00);
            wr(EPI_OFF_FLAGS, 8'h00);
            rd(EPI_OFF_FLAGS, fbit[p]);
            global_ie <= 1'b1;
            wait_irq();
            check({6'h00, irq_vec_id}, {6'h00, vid[p]});
            ack();
            repeat (3) @(negedge clk_sys);
            check({7'h00, irq}, 8'h00);
            rd(EPI_OFF_FLAGS, 8'h00);
        end
        $display("test vector done");
        // Low level keeps asking for as long as the pin stays low
        wr(EPI_OFF_CTLA, 8'h0c);
        wr(EPI_OFF_MASK, 8'h40);
        src.drive(0, 1'b0);
        wait_irq();
        for (m = 0; m < 5; m++)
        begin
            @(negedge clk_sys);
            check({7'h00, irq}, 8'h01);
        end
        check({7'h00, wake_req}, 8'h01);
        rd(EPI_OFF_FLAGS, 8'h00);
        src.drive(0, 1'b1);
        repeat (5) @(negedge clk_sys);
        check({7'h00, irq}, 8'h00);
        check({7'h00, wake_req}, 8'h00);
        $display("test level done");
        // Safe reselect of the pin-two edge, with a sleep glitch inside
        wr(EPI_OFF_MASK, 8'h00);
        rnd = {7'($urandom()), 1'b0};
        wr(EPI_OFF_CTLB, rnd);
        rd(EPI_OFF_CTLB, rnd);
        sleep_buf_off <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sleep_buf_off <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(EPI_OFF_FLAGS, 8'h20);
        wr(EPI_OFF_FLAGS, 8'h20);
        rd(EPI_OFF_FLAGS, 8'h00);
        wr(EPI_OFF_MASK, 8'h20);
        src.glitch_two();
        wait_irq();
        check({6'h00, irq_vec_id}, {6'h00, vid[2]});
        rd(EPI_OFF_FLAGS, 8'h20);
        wr(EPI_OFF_FLAGS, 8'h20);
        repeat (3) @(negedge clk_sys);
        check({7'h00, irq}, 8'h00);
        $display("test reselect done");
        repeat (4) @(posedge clk_sys);
        check(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule // tb_external_pin_interrupts
`default_nettype wire
